// *** ecr_regs.svh ***
`ifndef ECR_REGS_SVH
`define ECR_REGS_SVH

// ----------------------------------------------------------------
// record layout, in 32-bit word indices
// ----------------------------------------------------------------
`define ECR_REC_WORDS      1024
`define ECR_W_SIZE_LO      10'h000
`define ECR_W_SIZE_HI      10'h001
`define ECR_W_BASE_LO      10'h002
`define ECR_W_BASE_HI      10'h003
`define ECR_W_FRAME        10'h004
`define ECR_W_MISC         10'h005
`define ECR_W_ATTR0        10'h00C
`define ECR_W_ATTR1        10'h00D
`define ECR_W_ATTR2        10'h00E
`define ECR_W_ATTR3        10'h00F
`define ECR_W_BUILD_MEAS   10'h010
`define ECR_W_SIGNER_MEAS  10'h020
`define ECR_W_PROD_SVN     10'h040
`define ECR_W_TAIL_FIRST   10'h041
`define ECR_W_EID_LO       10'h041
`define ECR_W_EID_HI       10'h042
`define ECR_W_PAD_FIRST    10'h043
`define ECR_W_PAD_LAST     10'h09A
`define ECR_W_TAIL_LAST    10'h3FF
`define ECR_PAD_WORDS      7'h58

// ----------------------------------------------------------------
// control register byte addresses
// ----------------------------------------------------------------
`define ECR_A_RECORD_TOP   1'b1
`define ECR_A_PHYS         13'h1000
`define ECR_A_CAP_MISC     13'h1004
`define ECR_A_CAP_ATTR0    13'h1008
`define ECR_A_CAP_ATTR1    13'h100C
`define ECR_A_CAP_ATTR2    13'h1010
`define ECR_A_CAP_ATTR3    13'h1014
`define ECR_A_TGT_ATTR     13'h1018
`define ECR_A_PAD_DATA     13'h101C
`define ECR_A_CMD          13'h1020
`define ECR_A_STATUS       13'h1024

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ECR_PAGE_OFS_MSB   11
`define ECR_ATTR_INIT      0
`define ECR_ATTR_DEBUG     1
`define ECR_ATTR_WIDE      2
`define ECR_ATTR_RSV3      3
`define ECR_ATTR_PROV      4
`define ECR_ATTR_TOKEN     5
`define ECR_ATTR_RSV_LSB   6
`define ECR_MISC_RSV_LSB   1
`define ECR_F_ALIGN        0
`define ECR_F_SIZE         1
`define ECR_F_BASE         2
`define ECR_F_ATTR         3
`define ECR_F_MISC         4
`define ECR_F_TAIL         5
`define ECR_F_PERMIT       6
`define ECR_F_TARGET       7

`endif

// *** ecr_pkg.sv ***
package ecr_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_SCAN   = 2'b01,
    ST_FINISH = 2'b10
  } ecr_state_e;

  typedef enum logic [2:0]
  {
    OP_CREATE = 3'b000,
    OP_INIT   = 3'b001,
    OP_REPORT = 3'b010,
    OP_DBG_RD = 3'b011,
    OP_DBG_WR = 3'b100,
    OP_KEY_PV = 3'b101,
    OP_KEY_TK = 3'b110,
    OP_NONE   = 3'b111
  } ecr_op_e;

endpackage

// *** ecr_checker.sv ***
`timescale 1ns/1ps
`include "ecr_regs.svh"
// Operation
// - size field at 0, power of two
// - base at 8, aligned to size
// - frame page count at offset 16
// - extra info select vector at 20
// - attribute vector 16 bytes at 48
// - build measurement 32 bytes at 64
// - signer measurement 32 bytes at 128
// - product id at 256, version at 258
// - device keeps enclave identifier in tail
// - device keeps signature pad in tail
// - initialized bit clear at create, set later
// - debug bit gates debug read and write
// - bit 2 wide mode, bit 3 zero
// - bit 4 provisioning key, 63:6 reserved
// - bit 5 allows init token key
// - bits 127:64 extended state request mask
// - reject attribute ones not enumerated allowed
// - zero capability forces zero select vector
// - select bit 0 fault detail, rest zero
module ecr_checker
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // register port
  input  wire logic [12:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // operation result
  output logic             op_done,
  output logic             gp_fault,
  // enclave configuration
  output logic             enclave_initialized,
  output logic             wide_mode_flag,
  output logic             fault_detail_select,
  output logic      [31:0] save_frame_page_count,
  output logic      [31:0] extra_info_select_vector,
  output logic      [63:0] extended_state_request_mask,
  output logic      [15:0] product_identifier,
  output logic      [15:0] security_version_number
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0]  rec_mem [`ECR_REC_WORDS];
  logic [31:0]  phys_reg;
  logic [31:0]  cap_misc_reg;
  logic [127:0] cap_attr_reg;
  logic [31:0]  tgt_attr_reg;
  logic [6:0]   pad_idx_reg;
  logic [63:0]  eid_reg;
  logic         created_reg;
  ecr_pkg::ecr_state_e state_reg;
  ecr_pkg::ecr_op_e    op_reg;
  logic [9:0]   scan_idx_reg;
  logic         tail_bad_reg;
  logic [7:0]   field_fault_reg;
  logic [7:0]   fault_cause_reg;
  logic         last_fault_reg;

  // ----------------------------------------------------------------
  // record fields
  // ----------------------------------------------------------------
  logic [63:0]  rec_size;
  logic [63:0]  rec_base;
  logic [31:0]  rec_frame;
  logic [31:0]  rec_misc;
  logic [127:0] rec_attr;
  logic [31:0]  rec_prod_svn;
  logic         busy;
  logic         cmd_go;
  logic         is_record;
  logic [9:0]   word_idx;
  logic [7:0]   field_fault;
  logic [7:0]   fault_total;
  ecr_pkg::ecr_op_e cmd_op;

  assign rec_size     = {rec_mem[`ECR_W_SIZE_HI], rec_mem[`ECR_W_SIZE_LO]};
  assign rec_base     = {rec_mem[`ECR_W_BASE_HI], rec_mem[`ECR_W_BASE_LO]};
  assign rec_frame    = rec_mem[`ECR_W_FRAME];
  assign rec_misc     = rec_mem[`ECR_W_MISC];
  assign rec_attr     = {rec_mem[`ECR_W_ATTR3], rec_mem[`ECR_W_ATTR2],
                         rec_mem[`ECR_W_ATTR1], rec_mem[`ECR_W_ATTR0]};
  assign rec_prod_svn = rec_mem[`ECR_W_PROD_SVN];
  assign busy         = (state_reg != ecr_pkg::ST_IDLE);
  assign is_record    = (reg_addr[12] != `ECR_A_RECORD_TOP);
  assign word_idx     = reg_addr[11:2];
  assign cmd_op       = ecr_pkg::ecr_op_e'(reg_wdata[2:0]);
  assign cmd_go       = reg_wr && !busy && (reg_addr == `ECR_A_CMD);
  assign fault_total  = field_fault_reg | {2'h0, tail_bad_reg, 5'h00};

  // low bits of value under mask all clear
  function automatic logic aligned(input logic [63:0] value, input logic [63:0] mask);
    aligned = ((value & mask) == 64'h0);
  endfunction

  // ----------------------------------------------------------------
  // field checks, sampled when the command is taken
  // ----------------------------------------------------------------
  always_comb
  begin
    field_fault = 8'h00;
    unique case (cmd_op)
      ecr_pkg::OP_CREATE:
      begin
        field_fault[`ECR_F_ALIGN] = !aligned({32'h0, phys_reg},
                                             64'(12'hFFF));
        field_fault[`ECR_F_SIZE]  = (rec_size == 64'h0)
                                    || !aligned(rec_size, rec_size - 64'h1);
        field_fault[`ECR_F_BASE]  = !aligned(rec_base, rec_size - 64'h1);
        field_fault[`ECR_F_ATTR]  = rec_attr[`ECR_ATTR_INIT]
                                    || rec_attr[`ECR_ATTR_RSV3]
                                    || (rec_attr[63:`ECR_ATTR_RSV_LSB] != 58'h0)
                                    || ((rec_attr & ~cap_attr_reg) != 128'h0);
        field_fault[`ECR_F_MISC]  = ((cap_misc_reg == 32'h0) && (rec_misc != 32'h0))
                                    || (rec_misc[31:`ECR_MISC_RSV_LSB] != 31'h0)
                                    || ((rec_misc & ~cap_misc_reg) != 32'h0);
      end
      ecr_pkg::OP_INIT:
        field_fault[`ECR_F_PERMIT] = !created_reg || enclave_initialized;
      ecr_pkg::OP_REPORT:
        field_fault[`ECR_F_TARGET] = !tgt_attr_reg[`ECR_ATTR_INIT];
      ecr_pkg::OP_DBG_RD,
      ecr_pkg::OP_DBG_WR:
        field_fault[`ECR_F_PERMIT] = !created_reg || !rec_attr[`ECR_ATTR_DEBUG];
      ecr_pkg::OP_KEY_PV:
        field_fault[`ECR_F_PERMIT] = !created_reg || !rec_attr[`ECR_ATTR_PROV];
      ecr_pkg::OP_KEY_TK:
        field_fault[`ECR_F_PERMIT] = !created_reg || !rec_attr[`ECR_ATTR_TOKEN];
      ecr_pkg::OP_NONE:
        field_fault[`ECR_F_PERMIT] = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg       <= ecr_pkg::ST_IDLE;
      op_reg          <= ecr_pkg::OP_NONE;
      scan_idx_reg    <= `ECR_W_TAIL_FIRST;
      tail_bad_reg    <= 1'b0;
      field_fault_reg <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        ecr_pkg::ST_IDLE:
          if (cmd_go)
          begin
            op_reg          <= cmd_op;
            field_fault_reg <= field_fault;
            tail_bad_reg    <= 1'b0;
            scan_idx_reg    <= `ECR_W_TAIL_FIRST;
            if (cmd_op == ecr_pkg::OP_CREATE || cmd_op == ecr_pkg::OP_REPORT)
              state_reg <= ecr_pkg::ST_SCAN;
            else
              state_reg <= ecr_pkg::ST_FINISH;
          end
        ecr_pkg::ST_SCAN:
        begin
          // report skips words the device itself keeps in the tail
          if (rec_mem[scan_idx_reg] != 32'h0
              && !(op_reg == ecr_pkg::OP_REPORT && scan_idx_reg <= `ECR_W_PAD_LAST))
            tail_bad_reg <= 1'b1;
          scan_idx_reg <= scan_idx_reg + 10'h001;
          if (scan_idx_reg == `ECR_W_TAIL_LAST)
            state_reg <= ecr_pkg::ST_FINISH;
        end
        ecr_pkg::ST_FINISH:
          state_reg <= ecr_pkg::ST_IDLE;
        default:
          state_reg <= ecr_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // completion and fault report
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      op_done         <= 1'b0;
      gp_fault        <= 1'b0;
      fault_cause_reg <= 8'h00;
      last_fault_reg  <= 1'b0;
    end
    else
    begin
      op_done  <= (state_reg == ecr_pkg::ST_FINISH);
      gp_fault <= (state_reg == ecr_pkg::ST_FINISH) && (fault_total != 8'h00);
      if (state_reg == ecr_pkg::ST_FINISH)
      begin
        fault_cause_reg <= fault_total;
        last_fault_reg  <= (fault_total != 8'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // enclave state taken on a clean create or initialize
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      created_reg                 <= 1'b0;
      enclave_initialized         <= 1'b0;
      wide_mode_flag              <= 1'b0;
      fault_detail_select         <= 1'b0;
      save_frame_page_count       <= 32'h0;
      extra_info_select_vector    <= 32'h0;
      extended_state_request_mask <= 64'h0;
      product_identifier          <= 16'h0;
      security_version_number     <= 16'h0;
      eid_reg                     <= 64'h1;
    end
    else if (state_reg == ecr_pkg::ST_FINISH && fault_total == 8'h00)
    begin
      if (op_reg == ecr_pkg::OP_CREATE)
      begin
        created_reg                 <= 1'b1;
        enclave_initialized         <= 1'b0;
        wide_mode_flag              <= rec_attr[`ECR_ATTR_WIDE];
        fault_detail_select         <= rec_misc[0];
        save_frame_page_count       <= rec_frame;
        extra_info_select_vector    <= rec_misc;
        extended_state_request_mask <= rec_attr[127:64];
        product_identifier          <= rec_prod_svn[15:0];
        security_version_number     <= rec_prod_svn[31:16];
        eid_reg                     <= eid_reg + 64'h1;
      end
      if (op_reg == ecr_pkg::OP_INIT)
        enclave_initialized <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // record memory: software builds it, device writes its own words
  // ----------------------------------------------------------------
  // writes are dropped while an operation runs so checks see a stable record
  always_ff @(posedge clock)
  begin
    if (reg_wr && !busy && is_record)
      rec_mem[word_idx] <= reg_wdata;
    else if (reg_wr && !busy && reg_addr == `ECR_A_PAD_DATA)
      rec_mem[`ECR_W_PAD_FIRST + {3'h0, pad_idx_reg}] <= reg_wdata;
    else if (state_reg == ecr_pkg::ST_FINISH && fault_total == 8'h00)
    begin
      if (op_reg == ecr_pkg::OP_CREATE)
      begin
        rec_mem[`ECR_W_EID_LO] <= eid_reg[31:0];
        rec_mem[`ECR_W_EID_HI] <= eid_reg[63:32];
      end
      if (op_reg == ecr_pkg::OP_INIT)
        rec_mem[`ECR_W_ATTR0] <= rec_mem[`ECR_W_ATTR0] | 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      phys_reg     <= 32'h0;
      cap_misc_reg <= 32'h0;
      cap_attr_reg <= 128'h0;
      tgt_attr_reg <= 32'h0;
      pad_idx_reg  <= 7'h00;
    end
    else if (reg_wr && !busy)
    begin
      unique case (reg_addr)
        `ECR_A_PHYS:      phys_reg             <= reg_wdata;
        `ECR_A_CAP_MISC:  cap_misc_reg         <= reg_wdata;
        `ECR_A_CAP_ATTR0: cap_attr_reg[31:0]   <= reg_wdata;
        `ECR_A_CAP_ATTR1: cap_attr_reg[63:32]  <= reg_wdata;
        `ECR_A_CAP_ATTR2: cap_attr_reg[95:64]  <= reg_wdata;
        `ECR_A_CAP_ATTR3: cap_attr_reg[127:96] <= reg_wdata;
        `ECR_A_TGT_ATTR:  tgt_attr_reg         <= reg_wdata;
        `ECR_A_PAD_DATA:
          pad_idx_reg <= (pad_idx_reg == `ECR_PAD_WORDS - 7'h01) ? 7'h00
                         : pad_idx_reg + 7'h01;
        default:          pad_idx_reg          <= pad_idx_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      if (is_record)
        reg_rdata <= rec_mem[word_idx];
      else
        unique case (reg_addr)
          `ECR_A_PHYS:      reg_rdata <= phys_reg;
          `ECR_A_CAP_MISC:  reg_rdata <= cap_misc_reg;
          `ECR_A_CAP_ATTR0: reg_rdata <= cap_attr_reg[31:0];
          `ECR_A_CAP_ATTR1: reg_rdata <= cap_attr_reg[63:32];
          `ECR_A_CAP_ATTR2: reg_rdata <= cap_attr_reg[95:64];
          `ECR_A_CAP_ATTR3: reg_rdata <= cap_attr_reg[127:96];
          `ECR_A_TGT_ATTR:  reg_rdata <= tgt_attr_reg;
          `ECR_A_STATUS:
            reg_rdata <= {16'h0, fault_cause_reg, 4'h0, last_fault_reg,
                          enclave_initialized, created_reg, busy};
          default:          reg_rdata <= 32'h0;
        endcase
    end
    else
      reg_rdata <= 32'h0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  misalign_fault_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == ecr_pkg::ST_FINISH && op_reg == ecr_pkg::OP_CREATE
     && phys_reg[`ECR_PAGE_OFS_MSB:0] != 12'h000) |=> gp_fault && fault_cause_reg[0])
    else $error("misaligned record not faulted");

  size_pow2_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == ecr_pkg::ST_FINISH && op_reg == ecr_pkg::OP_CREATE
     && (rec_size & (rec_size - 64'h1)) != 64'h0) |=> gp_fault && fault_cause_reg[1])
    else $error("non power of two size accepted");

  base_align_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == ecr_pkg::ST_FINISH && op_reg == ecr_pkg::OP_CREATE
     && (rec_base & (rec_size - 64'h1)) != 64'h0) |=> gp_fault)
    else $error("unaligned base accepted");

  tail_scan_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == ecr_pkg::ST_SCAN && op_reg == ecr_pkg::OP_CREATE
     && rec_mem[scan_idx_reg] != 32'h0) |-> ##[1:1000] gp_fault)
    else $error("dirty tail accepted");

  init_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_go && cmd_op == ecr_pkg::OP_INIT && created_reg && !enclave_initialized)
    |-> ##2 enclave_initialized && rec_mem[`ECR_W_ATTR0][0] && !gp_fault)
    else $error("initialize did not set the flag");

  debug_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_go && (cmd_op == ecr_pkg::OP_DBG_RD || cmd_op == ecr_pkg::OP_DBG_WR))
    |-> ##2 op_done && (gp_fault == !$past(rec_attr[`ECR_ATTR_DEBUG], 2)
                        || !$past(created_reg, 2)))
    else $error("debug access gate wrong");

  wide_mode_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == ecr_pkg::ST_FINISH && op_reg == ecr_pkg::OP_CREATE
     && fault_total == 8'h00) |=> wide_mode_flag == $past(rec_attr[`ECR_ATTR_WIDE])
                                  && extended_state_request_mask == $past(rec_attr[127:64]))
    else $error("wide mode or mask not taken");

  key_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_go && cmd_op == ecr_pkg::OP_KEY_TK && !rec_attr[`ECR_ATTR_TOKEN])
    |-> ##2 gp_fault)
    else $error("token key given without permission");

  misc_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == ecr_pkg::ST_FINISH && op_reg == ecr_pkg::OP_CREATE
     && cap_misc_reg == 32'h0 && rec_misc != 32'h0) |=> gp_fault)
    else $error("select vector set with zero capability");

  abort_stable_a: assert property (@(posedge clock) disable iff (!rst_b)
    gp_fault |-> op_done && $stable(eid_reg) && $stable(rec_mem[`ECR_W_EID_LO]))
    else $error("faulted operation changed state");

endmodule

// *** ecr_sw_model.sv ***
`timescale 1ns/1ps
`include "ecr_regs.svh"
// ----------------------------------------------------------------
// software side: builds the record over the register port
// ----------------------------------------------------------------
module ecr_sw_model
(
  // clock and answers
  input  wire logic        clock,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        op_done,
  input  wire logic        gp_fault,
  // register port
  output logic      [12:0] reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  initial
  begin
    reg_addr  = 13'h0000;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // n counts cycles from the command cycle; 0 when no completion shows
  task automatic op(input logic [2:0] c, output logic f, output int n);
    wr(`ECR_A_CMD, {29'h0, c});
    f = 1'b0;
    n = 0;
    for (int i = 1; i <= 1200 && n == 0; i++)
    begin
      @(posedge clock);
      #1;
      if (op_done === 1'b1)
      begin
        n = i + 1;
        f = gp_fault;
      end
    end
  endtask
  // clean record; the tail loop is the long part of every build
  task automatic build(input logic [31:0] attr0);
    wr(`ECR_A_PHYS, 32'h0000_2000);
    wr(13'h0000, 32'h0000_1000);
    wr(13'h0004, 32'h0000_0000);
    wr(13'h0008, 32'h0000_4000);
    wr(13'h000C, 32'h0000_0000);
    wr(13'h0010, 32'h0000_0003);
    wr(13'h0014, 32'h0000_0001);
    wr(13'h0030, attr0);
    wr(13'h0034, 32'h0000_0000);
    wr(13'h0038, 32'h0000_0007);
    wr(13'h003C, 32'h0000_0000);
    wr(13'h0100, 32'h0002_0007);
    for (int w = 'h41; w <= 'h3FF; w++)
      wr({1'b0, 10'(w), 2'b00}, 32'h0000_0000);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "ecr_regs.svh"
module tb;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [12:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        op_done;
  logic        gp_fault;
  logic        init_flag;
  logic        wide;
  logic        fdet;
  logic [31:0] frames;
  logic [31:0] sel;
  logic [63:0] xmask;
  logic [15:0] prod;
  logic [15:0] svn;
  int          error_cnt = 0;
  int          total_checks = 0;

  always #5 clock = ~clock;

  ecr_sw_model u_sw
  (
    .clock(clock), .reg_rdata(reg_rdata), .op_done(op_done), .gp_fault(gp_fault),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
  );
  ecr_checker u_dut
  (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_done(op_done),
    .gp_fault(gp_fault), .enclave_initialized(init_flag), .wide_mode_flag(wide),
    .fault_detail_select(fdet), .save_frame_page_count(frames),
    .extra_info_select_vector(sel), .extended_state_request_mask(xmask),
    .product_identifier(prod), .security_version_number(svn)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one operation, then outcome and the cause field of the status word;
  // cause is the bit index of the failed check in that field
  task automatic run(input logic [2:0] c, input logic f, input logic [7:0] cause);
    logic        got;
    int          n;
    logic [31:0] st;
    u_sw.op(c, got, n);
    chk(n != 0, 1'b1, "operation never completed");
    chk(got, f, "fault pulse");
    u_sw.rd(`ECR_A_STATUS, st);
    chk(st[3], f, "status faulted bit");
    if (f)
      chk(st[15:8], 8'h01 << cause[2:0], "fault cause");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    chk({op_done, gp_fault, init_flag, wide, fdet}, 0, "reset flags");
    chk({sel, prod, svn}, 0, "reset select and identity");
    chk({frames, xmask[31:0]}, 0, "reset frames and mask low");
    chk(xmask, 0, "reset mask");
    u_sw.rd(13'h1FFC, d);
    chk(d, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_bad_create;
    logic [12:0] a [9] = '{13'h1000, 13'h0000, 13'h0008, 13'h0030, 13'h0030,
                           13'h0034, 13'h0014, 13'h1004, 13'h0FFC};
    logic [31:0] bv [9] = '{32'h2800, 32'h3, 32'h4800, 32'h1C, 32'h15, 32'h1, 32'h2,
                            32'h0, 32'h1};
    logic [31:0] gv [9] = '{32'h2000, 32'h1000, 32'h4000, 32'h14, 32'h14, 32'h0,
                            32'h1, 32'h1, 32'h0};
    logic [7:0]  cs [9] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h3, 8'h3, 8'h4, 8'h4, 8'h5};
    for (int i = 0; i < 9; i++)
    begin
      u_sw.wr(a[i], bv[i]);
      run(ecr_pkg::OP_CREATE, 1'b1, cs[i]);
      chk(wide, 1'b0, "config moved by failed create");
      u_sw.wr(a[i], gv[i]);
    end
    $display("test bad create done");
  endtask
  task automatic t_create;
    logic        f;
    int          n;
    logic [31:0] d;
    u_sw.op(ecr_pkg::OP_CREATE, f, n);
    chk(n, 961, "create latency");
    chk(f, 1'b0, "clean create faulted");
    chk({wide, fdet, init_flag}, 3'b110, "mode flags");
    chk(frames, 32'h3, "frame pages");
    chk(sel, 32'h1, "select vector");
    chk(xmask, 64'h7, "state mask");
    chk({svn, prod}, 32'h0002_0007, "product and version");
    u_sw.rd(13'h0104, d);
    chk(d, 32'h1, "identifier low word");
    $display("test create done");
  endtask
  task automatic t_ops;
    logic [31:0] d;
    run(ecr_pkg::OP_DBG_RD, 1'b1, 8'h6);
    run(ecr_pkg::OP_DBG_WR, 1'b1, 8'h6);
    run(ecr_pkg::OP_KEY_PV, 1'b0, 8'h0);
    run(ecr_pkg::OP_KEY_TK, 1'b1, 8'h6);
    run(ecr_pkg::OP_NONE, 1'b1, 8'h6);
    u_sw.wr(`ECR_A_TGT_ATTR, 32'h0);
    run(ecr_pkg::OP_REPORT, 1'b1, 8'h7);
    run(ecr_pkg::OP_INIT, 1'b0, 8'h0);
    chk(init_flag, 1'b1, "initialized level");
    u_sw.rd(13'h0030, d);
    chk(d[0], 1'b1, "initialized attribute bit");
    run(ecr_pkg::OP_INIT, 1'b1, 8'h6);
    u_sw.wr(`ECR_A_TGT_ATTR, 32'h1);
    run(ecr_pkg::OP_REPORT, 1'b0, 8'h0);
    $display("test operations done");
  endtask
  task automatic t_debug;
    logic [31:0] d;
    u_sw.wr(13'h0104, 32'h0);
    u_sw.wr(13'h0108, 32'h0);
    u_sw.wr(13'h0030, 32'h0000_0002);
    u_sw.wr(`ECR_A_CAP_ATTR0, 32'h0000_0035);
    run(ecr_pkg::OP_CREATE, 1'b1, 8'h3);
    u_sw.wr(`ECR_A_CAP_ATTR0, 32'h0000_0037);
    run(ecr_pkg::OP_CREATE, 1'b0, 8'h0);
    chk({init_flag, wide}, 2'b00, "flags after recreate");
    run(ecr_pkg::OP_DBG_RD, 1'b0, 8'h0);
    run(ecr_pkg::OP_DBG_WR, 1'b0, 8'h0);
    u_sw.wr(13'h0040, 32'hA5A5_0001);
    u_sw.wr(13'h0080, 32'h5A5A_0002);
    u_sw.wr(`ECR_A_PAD_DATA, 32'h0000_00C3);
    u_sw.rd(13'h0040, d);
    chk(d, 32'hA5A5_0001, "build measurement word");
    u_sw.rd(13'h0080, d);
    chk(d, 32'h5A5A_0002, "signer measurement word");
    u_sw.rd(13'h010C, d);
    chk(d, 32'h0000_00C3, "first pad word");
    run(ecr_pkg::OP_REPORT, 1'b0, 8'h0);
    $display("test debug done");
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    u_sw.wr(`ECR_A_CAP_MISC, 32'h1);
    u_sw.wr(`ECR_A_CAP_ATTR0, 32'h0000_0037);
    u_sw.wr(`ECR_A_CAP_ATTR2, 32'hFFFF_FFFF);
    u_sw.build(32'h0000_0014);
    t_bad_create();
    t_create();
    t_ops();
    t_debug();
    tally_and_finish();
  end

  initial
  begin
    #500_000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
